// file: include/rfb_pkg.sv
// Package of constants, types and register map for the free descriptor monitor.
// Summary of operation
// - Writing a ring base also sets its freed pointer to the first slot.
// - After a base write with no same-cycle write-back to that ring, the free count equals the whole ring size.
// - Each descriptor write-back with receive enabled advances the current descriptor pointer, unless it equals the freed pointer after hardware advance.
// - Flow control is requested while ring distance is below the threshold.
// - Any active ring below its own threshold requests flow control.
// - Back pressure ends only when every active ring meets its threshold.
// - No zero-time pause frame is sent; the far-end timer runs out.
// - Free count uses size minus current plus freed, or freed minus current.
// - Equal pointers mean empty after software, one left after hardware advance, none once a further write-back sets full.
// - In full duplex, send pause and resend at half the pause time if needed.
// - The link hold output stays high while any active ring's threshold is unmet.
package rfb_pkg;

  localparam int unsigned RFB_RINGS = 8;
  localparam int unsigned RFB_IDX_W = 16;
  localparam int unsigned RFB_AW    = 8;
  localparam int unsigned RFB_DW    = 32;
  localparam int unsigned RFB_DESC_BYTES = 8;
  localparam int unsigned RFB_DESC_SHIFT = 3;

  // Per-ring register index is {ring, field}; byte address is index times 4.
  localparam logic [1:0] RFB_F_BASE  = 2'h0;
  localparam logic [1:0] RFB_F_PARAM = 2'h1;
  localparam logic [1:0] RFB_F_FREED = 2'h2;
  localparam logic [1:0] RFB_F_CUR   = 2'h3;
  localparam logic [RFB_AW-1:0] RFB_A_CTRL   = 8'h80;
  localparam logic [RFB_AW-1:0] RFB_A_PAUSE  = 8'h84;
  localparam logic [RFB_AW-1:0] RFB_A_STATUS = 8'h88;

  localparam logic [15:0] RFB_PAUSE_RST = 16'h00ff;
  // One pause quantum is 512 bit times; at 1 Gb/s that is 512 ns.
  localparam int unsigned RFB_QUANTUM_NS = 512;
  localparam int unsigned RFB_CLK_NS     = 5;
  localparam int unsigned RFB_QUANTUM_CYC =
    (RFB_QUANTUM_NS + RFB_CLK_NS - 1) / RFB_CLK_NS;
  localparam logic [7:0] RFB_QCYC = 8'(RFB_QUANTUM_CYC);

  typedef enum logic [2:0] {
    RFB_IDLE  = 3'b001,
    RFB_SEND  = 3'b010,
    RFB_WAIT  = 3'b100
  } rfb_st_t;

endpackage

// file: rtl/rfb_backpressure.sv
// Receive free-descriptor monitor driving pause and link hold requests.
module rfb_backpressure
  import rfb_pkg::*;
#(
  parameter int unsigned RINGS = RFB_RINGS
)(
  input  wire logic                 i_clk,
  input  wire logic                 i_sys_rst,
  input  wire logic [RFB_AW-1:0]    i_addr,
  input  wire logic [RFB_DW-1:0]    i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [RFB_DW-1:0]    o_rdata,
  input  wire logic                 i_wb_valid,
  input  wire logic [2:0]           i_wb_ring,
  input  wire logic                 i_full_duplex,
  input  wire logic                 i_pause_done,
  output logic                      o_pause_req,
  output logic [15:0]               o_pause_time,
  output logic                      o_link_flow_hold,
  output logic                      o_rx_enable
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [RINGS-1:0][RFB_DW-1:0]    base;
    logic [RINGS-1:0][RFB_IDX_W-1:0] ring_size;
    logic [RINGS-1:0][RFB_IDX_W-1:0] thr;
    logic [RINGS-1:0][RFB_IDX_W-1:0] freed;
    logic [RINGS-1:0][RFB_IDX_W-1:0] cur;
    logic [RINGS-1:0]                sw_eq;
    logic [RINGS-1:0]                full;
    logic [RINGS-1:0]                active;
    logic                            rx_en;
    logic [15:0]                     pause_time_value;
    logic [RINGS-1:0]                below;
    logic                            hold;
    rfb_st_t                         st;
    logic [7:0]                      qcyc;
    logic [15:0]                     pause_quanta_count;
    logic [RFB_DW-1:0]               rdata;
    logic                            rd_base;
  } rfb_state_t;

  rfb_state_t s_ff;
  rfb_state_t nxt_s;
  logic [RINGS-1:0][RFB_IDX_W-1:0] free_cnt;
  logic [RINGS-1:0] below_now;
  logic [RFB_DW-1:0] base_rd;
  logic [2:0] wring;
  logic [1:0] wfld;
  logic       ring_acc;

  assign wring    = i_addr[6:4];
  assign wfld     = i_addr[3:2];
  assign ring_acc = (i_addr[7] == 1'b0);

  // Base addresses are also kept in a small memory for the read path.
  rfb_ring_mem #(.DEPTH(RINGS), .W(RFB_DW)) u_base_mem (
    .i_clk   (i_clk),
    .i_we    (i_wr && ring_acc && (wfld == RFB_F_BASE)),
    .i_waddr (wring),
    .i_wdata (i_wdata),
    .i_raddr (wring),
    .o_rdata (base_rd)
  );

  // Byte address to descriptor index relative to the ring base.
  function automatic logic [RFB_IDX_W-1:0] to_idx(
    input logic [RFB_DW-1:0] addr,
    input logic [RFB_DW-1:0] base);
    logic [RFB_DW-1:0] diff;
    diff = addr - base;
    return diff[RFB_IDX_W+RFB_DESC_SHIFT-1:RFB_DESC_SHIFT];
  endfunction

  // ****************************************************************
  // Free count per ring
  // ****************************************************************
  always_comb
  begin
    for (int r = 0; r < RINGS; r++)
    begin
      if (s_ff.freed[r] < s_ff.cur[r])
      begin
        free_cnt[r] = s_ff.ring_size[r] - s_ff.cur[r] + s_ff.freed[r];
      end
      else if (s_ff.freed[r] > s_ff.cur[r])
      begin
        free_cnt[r] = s_ff.freed[r] - s_ff.cur[r];
      end
      else if (s_ff.sw_eq[r])
      begin
        free_cnt[r] = s_ff.ring_size[r];
      end
      else if (s_ff.full[r])
      begin
        free_cnt[r] = '0;
      end
      else
      begin
        free_cnt[r] = 16'h0001;
      end
      below_now[r] = s_ff.active[r] && (free_cnt[r] < s_ff.thr[r]);
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    logic any_below;
    any_below = |s_ff.below;
    nxt_s = s_ff;
    nxt_s.below = below_now;
    nxt_s.hold = any_below;
    nxt_s.rdata = '0;
    nxt_s.rd_base = 1'b0;

    if (i_wr)
    begin
      if (ring_acc)
      begin
        case (wfld)
          RFB_F_BASE:
          begin
            nxt_s.base[wring]  = i_wdata;
            nxt_s.freed[wring] = '0;
            nxt_s.cur[wring]   = '0;
            nxt_s.sw_eq[wring] = 1'b1;
            nxt_s.full[wring]  = 1'b0;
          end
          RFB_F_PARAM:
          begin
            nxt_s.ring_size[wring] = i_wdata[15:0];
            nxt_s.thr[wring]       = i_wdata[31:16];
          end
          RFB_F_FREED:
          begin
            nxt_s.freed[wring] = to_idx(i_wdata, s_ff.base[wring]);
            nxt_s.sw_eq[wring] = 1'b1;
            nxt_s.full[wring]  = 1'b0;
          end
          default:
          begin
          end
        endcase
      end
      else if (i_addr == RFB_A_CTRL)
      begin
        nxt_s.rx_en  = i_wdata[8];
        nxt_s.active = i_wdata[RINGS-1:0];
      end
      else if (i_addr == RFB_A_PAUSE)
      begin
        nxt_s.pause_time_value = i_wdata[15:0];
      end
    end

    // Hardware write-back after a same-cycle software write still advances.
    if (i_wb_valid && s_ff.rx_en)
    begin
      if ((s_ff.cur[i_wb_ring] == s_ff.freed[i_wb_ring])
          && !s_ff.sw_eq[i_wb_ring])
      begin
        nxt_s.full[i_wb_ring] = 1'b1;
      end
      else
      begin
        if (s_ff.cur[i_wb_ring] + 16'h0001 >= s_ff.ring_size[i_wb_ring])
        begin
          nxt_s.cur[i_wb_ring] = '0;
        end
        else
        begin
          nxt_s.cur[i_wb_ring] = s_ff.cur[i_wb_ring] + 16'h0001;
        end
        nxt_s.sw_eq[i_wb_ring] = 1'b0;
      end
    end

    if (i_rd)
    begin
      if (ring_acc)
      begin
        case (wfld)
          RFB_F_BASE:  nxt_s.rd_base = 1'b1;
          RFB_F_PARAM: nxt_s.rdata = {s_ff.thr[wring], s_ff.ring_size[wring]};
          RFB_F_FREED: nxt_s.rdata = {16'h0, s_ff.freed[wring]};
          default:     nxt_s.rdata = {16'h0, s_ff.cur[wring]};
        endcase
      end
      else if (i_addr == RFB_A_CTRL)
      begin
        nxt_s.rdata = {23'h0, s_ff.rx_en, s_ff.active};
      end
      else if (i_addr == RFB_A_PAUSE)
      begin
        nxt_s.rdata = {16'h0, s_ff.pause_time_value};
      end
      else if (i_addr == RFB_A_STATUS)
      begin
        nxt_s.rdata = {23'h0, s_ff.hold, s_ff.below};
      end
    end

    // Pause sequencing; nothing is sent when the hold drops.
    case (s_ff.st)
      RFB_IDLE:
      begin
        if (any_below && i_full_duplex)
        begin
          nxt_s.st = RFB_SEND;
        end
      end
      RFB_SEND:
      begin
        if (i_pause_done)
        begin
          nxt_s.st = RFB_WAIT;
          nxt_s.qcyc = '0;
          nxt_s.pause_quanta_count = '0;
        end
      end
      default:
      begin
        if (s_ff.qcyc == RFB_QCYC - 8'h01)
        begin
          nxt_s.qcyc = '0;
          nxt_s.pause_quanta_count = s_ff.pause_quanta_count + 16'h0001;
        end
        else
        begin
          nxt_s.qcyc = s_ff.qcyc + 8'h01;
        end
        if (s_ff.pause_quanta_count >= (s_ff.pause_time_value >> 1))
        begin
          nxt_s.st = (any_below && i_full_duplex) ? RFB_SEND : RFB_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      s_ff <= '0;
      s_ff.pause_time_value <= RFB_PAUSE_RST;
      s_ff.st <= RFB_IDLE;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign o_rdata          = s_ff.rd_base ? base_rd : s_ff.rdata;
  assign o_pause_req      = (s_ff.st == RFB_SEND);
  assign o_pause_time     = s_ff.pause_time_value;
  assign o_link_flow_hold = s_ff.hold;
  assign o_rx_enable      = s_ff.rx_en;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_hold_follows;
    @(posedge i_clk) disable iff (i_sys_rst)
    (|below_now) |-> ##2 o_link_flow_hold;
  endproperty
  a_hold_follows: assert property (p_hold_follows)
    else $error("hold not raised after ring below threshold");

  property p_hold_release;
    @(posedge i_clk) disable iff (i_sys_rst)
    !(|below_now) |-> ##2 !o_link_flow_hold;
  endproperty
  a_hold_release: assert property (p_hold_release)
    else $error("hold kept with all rings satisfied");

  property p_base_init;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_wr && ring_acc && wfld == RFB_F_BASE && !i_wb_valid)
      |=> (s_ff.freed[$past(wring)] == '0) && s_ff.sw_eq[$past(wring)];
  endproperty
  a_base_init: assert property (p_base_init)
    else $error("base write did not reset freed pointer");

  property p_no_zero_pause;
    @(posedge i_clk) disable iff (i_sys_rst)
    $rose(o_pause_req) |-> $past(|s_ff.below);
  endproperty
  a_no_zero_pause: assert property (p_no_zero_pause)
    else $error("pause request without back pressure");

  property p_below_calc;
    @(posedge i_clk) disable iff (i_sys_rst)
    ##1 (s_ff.below == $past(below_now));
  endproperty
  a_below_calc: assert property (p_below_calc)
    else $error("below flags lag their comparison");

  property p_empty_full;
    @(posedge i_clk) disable iff (i_sys_rst)
    s_ff.sw_eq[0] && s_ff.cur[0] == s_ff.freed[0]
      |-> free_cnt[0] == s_ff.ring_size[0];
  endproperty
  a_empty_full: assert property (p_empty_full)
    else $error("empty ring not counted as full size");

  property p_advance;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_wb_valid && s_ff.rx_en && s_ff.sw_eq[i_wb_ring] && !i_wr)
      |=> s_ff.cur[$past(i_wb_ring)] != $past(s_ff.cur[i_wb_ring])
          || s_ff.ring_size[$past(i_wb_ring)] <= 16'h0001;
  endproperty
  a_advance: assert property (p_advance)
    else $error("write-back did not advance pointer");

  property p_pause_fd;
    @(posedge i_clk) disable iff (i_sys_rst)
    (s_ff.st == RFB_IDLE && |s_ff.below && i_full_duplex) |=> o_pause_req;
  endproperty
  a_pause_fd: assert property (p_pause_fd)
    else $error("no pause issued in full duplex");

  c_pause: cover property (@(posedge i_clk) o_pause_req ##[1:20] i_pause_done);
  c_hold:  cover property (@(posedge i_clk) o_link_flow_hold ##1 !o_link_flow_hold);
  c_full:  cover property (@(posedge i_clk) |s_ff.full);

endmodule

// file: rtl/rfb_ring_mem.sv
// Small register-file memory holding one word per ring, registered read.
module rfb_ring_mem
  import rfb_pkg::*;
#(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned W     = 32
)(
  input  wire logic                     i_clk,
  input  wire logic                     i_we,
  input  wire logic [$clog2(DEPTH)-1:0] i_waddr,
  input  wire logic [W-1:0]             i_wdata,
  input  wire logic [$clog2(DEPTH)-1:0] i_raddr,
  output logic      [W-1:0]             o_rdata
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule

// file: tb/rfb_far_end.sv
// Far-end link partner model that takes pause frame requests.
module rfb_far_end
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_slow,
  input  wire logic        i_pause_req,
  input  wire logic [15:0] i_pause_time,
  output logic             o_pause_done,
  output logic [7:0]       o_pause_cnt,
  output logic             o_zero_seen
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [1:0] st;
  logic [4:0] wait_cnt;

  // ************************************************************
  // Frame send and answer
  // ************************************************************
  // After the done pulse one cycle is skipped, because the request is
  // still seen high at the edge that takes the done pulse.
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      st           <= 2'h0;
      wait_cnt     <= 5'h00;
      o_pause_done <= 1'b0;
      o_pause_cnt  <= 8'h00;
      o_zero_seen  <= 1'b0;
    end
    else if (st == 2'h0 && i_pause_req === 1'b1)
    begin
      st          <= 2'h1;
      wait_cnt    <= i_slow ? 5'h14 : 5'h01;
      o_pause_cnt <= o_pause_cnt + 8'h01;
      if (i_pause_time === 16'h0000)
        o_zero_seen <= 1'b1;
    end
    else if (st == 2'h1)
    begin
      if (wait_cnt == 5'h00)
      begin
        o_pause_done <= 1'b1;
        st           <= 2'h2;
      end
      else
        wait_cnt <= wait_cnt - 5'h01;
    end
    else if (st == 2'h2)
    begin
      o_pause_done <= 1'b0;
      st           <= 2'h0;
    end
  end
endmodule

// file: tb/test_rfb_backpressure.sv
// Self-checking bench for the free-descriptor back-pressure monitor.
`define CHK(nm, ex, got) \
  begin \
    cmp_count++; \
    if ((got) !== (ex)) \
    begin \
      fail_count++; \
      $display("[FAIL] %s exp %0h got %0h", nm, ex, got); \
    end \
  end

module test_rfb_backpressure
  import rfb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic              i_clk = 1'b0;
  logic              i_sys_rst = 1'b1;
  logic [RFB_AW-1:0] i_addr = '0;
  logic [RFB_DW-1:0] i_wdata = '0;
  logic              i_wr = 1'b0;
  logic              i_rd = 1'b0;
  logic [RFB_DW-1:0] o_rdata;
  logic              i_wb_valid = 1'b0;
  logic [2:0]        i_wb_ring = 3'h0;
  logic              i_full_duplex = 1'b0;
  logic              i_pause_done;
  logic              o_pause_req;
  logic [15:0]       o_pause_time;
  logic              o_link_flow_hold;
  logic              o_rx_enable;
  logic              slow = 1'b0;
  logic [7:0]        pause_cnt;
  logic [7:0]        cnt_mark;
  logic              zero_seen;
  int                fail_count = 0;
  int                cmp_count = 0;

  always #2.5 i_clk = ~i_clk;

  rfb_backpressure u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_wb_valid(i_wb_valid), .i_wb_ring(i_wb_ring),
    .i_full_duplex(i_full_duplex), .i_pause_done(i_pause_done),
    .o_pause_req(o_pause_req), .o_pause_time(o_pause_time),
    .o_link_flow_hold(o_link_flow_hold), .o_rx_enable(o_rx_enable));

  rfb_far_end u_far (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_slow(slow),
    .i_pause_req(o_pause_req), .i_pause_time(o_pause_time),
    .o_pause_done(i_pause_done), .o_pause_cnt(pause_cnt),
    .o_zero_seen(zero_seen));

  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e,
                        input string nm);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    `CHK(nm, e, o_rdata)
  endtask

  task automatic wb(input logic [2:0] r);
    @(posedge i_clk);
    i_wb_valid <= 1'b1;
    i_wb_ring  <= r;
    @(posedge i_clk);
    i_wb_valid <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask

  // Pointer changes reach the hold output two cycles after the write.
  task automatic wr_settle(input logic [7:0] a, input logic [31:0] d);
    wr(a, d);
    repeat (3) @(posedge i_clk);
  endtask

  task automatic wait_pause(input logic [7:0] n);
    int i;
    i = 0;
    while (pause_cnt < n && i < 2000)
    begin
      @(posedge i_clk);
      i++;
    end
    `CHK("pause count", 1'b1, pause_cnt >= n)
    if (pause_cnt < n)
      test_done();
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    `CHK("pause time rst", 16'h00ff, o_pause_time)
    chk_rd(8'h88, 32'h0, "status rst");
    wr(8'h90, 32'hffffffff);
    chk_rd(8'h90, 32'h0, "unmapped");
    wr(8'h00, 32'h00001000);
    wr(8'h04, 32'h00040008);
    wr(8'h10, 32'h00002000);
    wr(8'h14, 32'h00020010);
    chk_rd(8'h10, 32'h00002000, "base ring1");
    wb(3'h0);
    chk_rd(8'h0c, 32'h0, "cur while off");
    wr(8'h84, 32'h00000004);
    wr_settle(8'h80, 32'h00000103);
    `CHK("rx enable", 1'b1, o_rx_enable)
    chk_rd(8'h88, 32'h0, "status empty");
    repeat (4) wb(3'h0);
    chk_rd(8'h0c, 32'h4, "cur ring0");
    chk_rd(8'h88, 32'h0, "status at thr");
    wb(3'h0);
    chk_rd(8'h88, 32'h101, "status below");
    `CHK("hold", 1'b1, o_link_flow_hold)
    repeat (300) @(posedge i_clk);
    `CHK("half duplex pause", 8'h00, pause_cnt)
    i_full_duplex <= 1'b1;
    wait_pause(8'h01);
    slow <= 1'b1;
    wait_pause(8'h02);
    wr_settle(8'h08, 32'h00001038);
    chk_rd(8'h88, 32'h101, "status free2");
    wr_settle(8'h08, 32'h00001008);
    chk_rd(8'h88, 32'h0, "status wrap");
    repeat (3) wb(3'h1);
    wr_settle(8'h18, 32'h00002020);
    chk_rd(8'h88, 32'h102, "ring1 below");
    wr_settle(8'h18, 32'h00002028);
    chk_rd(8'h88, 32'h0, "all met");
    `CHK("hold off", 1'b0, o_link_flow_hold)
    repeat (40) @(posedge i_clk);
    cnt_mark = pause_cnt;
    repeat (800) @(posedge i_clk);
    `CHK("no exit pause", cnt_mark, pause_cnt)
    wr(8'h04, 32'h00010008);
    wr_settle(8'h08, 32'h00001030);
    chk_rd(8'h88, 32'h0, "free one");
    wb(3'h0);
    chk_rd(8'h0c, 32'h6, "cur meets freed");
    chk_rd(8'h88, 32'h0, "one left");
    wb(3'h0);
    chk_rd(8'h88, 32'h101, "ring full");
    wr_settle(8'h00, 32'h00001000);
    chk_rd(8'h08, 32'h0, "freed after base");
    chk_rd(8'h88, 32'h0, "empty after base");
    wr_settle(8'h08, 32'h00001000);
    chk_rd(8'h88, 32'h0, "sw equal empty");
    `CHK("zero pause", 1'b0, zero_seen)
    test_done();
  end
endmodule
